// ### design/isr_status.sv
// Purpose: Status reporting registers, summaries and queues of the instrument
// Assumes: Command strobes are single-cycle and synchronous; condition pins are async
// Notes:   Response words appear one cycle after the query strobe
//
// Summary of operation
// - Masked standard events still latch, no summary
// - Run bit 3, wait bit 5, overload 11
// - Run flag while acquisition not stopped
// - Wait flag follows arm latch
// - Overload flag on 50 ohm input overload
// - Operation summary bit 7 from enabled flags
// - Operation register query returns then clears
// - Enable mask gates operation summary
// - Arming sets latch, wait flag, summary
// - Arm latch holds until query or clear
// - Errors queued first-in first-out
// - Overflow keeps oldest, writes marker 350
// - Thirty entries, last reserved for marker
// - Error query pops the oldest entry
// - Empty queue reads code zero
// - Error queue emptied at reset, clear
// - Message available bit 4 when output pending
// - One-entry advisory message holding
// - Advisory writes never set message bit
// - Clear status empties events and queues
// - Clear after terminator also flushes output
// - Standard event summary bit 5 when enabled
`timescale 1ns/1ps
module isr_status #(
	parameter int MSG_WIDTH = isr_pkg::MSG_W
) (
	// Clock and reset
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	// Commands from the parser
	input  wire isr_pkg::isr_cmd_s     cmd_in,
	input  wire logic [15:0]          mask_data_in,
	input  wire logic [7:0]           ese_data_in,
	input  wire logic [MSG_WIDTH-1:0] dsp_text_in,
	// Instrument conditions, asynchronous
	input  wire logic                 acq_running_in,
	input  wire logic                 armed_in,
	input  wire logic                 input_overload_in,
	// Events from the instrument, synchronous
	input  wire logic [7:0]           std_event_in,
	input  wire isr_pkg::isr_err_s     err_push_in,
	input  wire logic                 out_queue_nonempty_in,
	// Responses
	output logic [15:0]               operation_condition_flags_out,
	output logic                      arm_latch_out,
	output logic [15:0]               err_code_out,
	output logic [7:0]                standard_event_flags_out,
	output logic [MSG_WIDTH-1:0]      dsp_text_out,
	output logic [7:0]                status_byte_out,
	output logic                      out_queue_flush_out,
	output logic [5:0]                err_count_out
);

	// All state in one record
	typedef struct packed {
		logic [1:0]           run_sync;     // Run condition synchroniser
		logic [1:0]           arm_sync;     // Armed condition synchroniser
		logic [1:0]           ovl_sync;     // Overload synchroniser
		logic                 arm_prev;     // Previous armed level for edge
		logic [15:0]          opc;          // Operation condition flags
		logic [15:0]          mask;         // Operation enable mask
		logic                 arm_latch;    // Arm event latch
		logic [7:0]           evt;          // Standard event flags
		logic [7:0]           sese;         // Standard event enable
		logic [MSG_WIDTH-1:0] advisory_message_bit;          // Advisory message queue
		logic [15:0]          opc_rd;       // Operation read word
		logic                 arm_rd;       // Arm read word
		logic [7:0]           evt_rd;       // Standard event read word
		logic [15:0]          err_rd;       // Error read word
		logic [7:0]           stb;          // Status byte
		logic                 flush;        // Output queue flush pulse
		logic [5:0]           err_cnt;      // Error count mirror, one cycle late
	} isr_state_s;

	isr_state_s s_q;   // Registered state
	isr_state_s s_d;   // Next state

	logic [15:0] err_head;   // Head of error queue
	logic [5:0]  err_count;  // Entries in error queue

	// Error queue, popped by the error query and cleared by clear status
	isr_err_queue #(
		.DEPTH (isr_pkg::ERRQ_DEPTH)
	) u_errq (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.push_in    (err_push_in),
		.pop_in     (cmd_in.err_read),
		.clear_in   (cmd_in.cls),
		.head_out   (err_head),
		.count_out  (err_count)
	);

	// Next-state logic for every flag, summary and read word
	always_comb
	begin
		logic run_s;
		logic arm_s;
		logic ovl_s;
		logic arm_rise;
		logic [15:0] opc_set;
		logic [15:0] opc_n;
		logic [7:0]  evt_n;
		logic        arm_n;
		run_s = s_q.run_sync[1];
		arm_s = s_q.arm_sync[1];
		ovl_s = s_q.ovl_sync[1];
		s_d = s_q;

		// Two-stage synchronisers; only stage two is read below
		s_d.run_sync = {s_q.run_sync[0], acq_running_in};
		s_d.arm_sync = {s_q.arm_sync[0], armed_in};
		s_d.ovl_sync = {s_q.ovl_sync[0], input_overload_in};
		s_d.arm_prev = arm_s;
		arm_rise     = arm_s & ~s_q.arm_prev;

		// Arm latch: read clears, but a new arming in the same cycle wins
		arm_n = s_q.arm_latch;
		if (cmd_in.arm_read || cmd_in.cls)
			arm_n = 1'b0;
		if (arm_rise)
			arm_n = 1'b1;
		s_d.arm_latch = arm_n;

		// Conditions that set operation flags this cycle
		opc_set = 16'h0000;
		opc_set[isr_pkg::OPC_RUN_BIT]  = run_s;
		opc_set[isr_pkg::OPC_WAIT_BIT] = arm_n;
		opc_set[isr_pkg::OPC_OVLD_BIT] = ovl_s;

		// Read returns current word then clears; live conditions re-set it
		opc_n = s_q.opc;
		if (cmd_in.opc_read || cmd_in.cls)
			opc_n = 16'h0000;
		opc_n = opc_n | opc_set;
		s_d.opc = opc_n;
		s_d.opc_rd = cmd_in.opc_read ? s_q.opc : s_q.opc_rd;

		// Operation enable mask written by the controller
		if (cmd_in.mask_write)
			s_d.mask = mask_data_in;

		// Standard events latch whether enabled or not
		// A new event in the clearing cycle survives, so none is lost
		evt_n = s_q.evt;
		if (cmd_in.esr_read || cmd_in.cls)
			evt_n = 8'h00;
		evt_n = evt_n | std_event_in;
		s_d.evt = evt_n;
		s_d.evt_rd = cmd_in.esr_read ? s_q.evt : s_q.evt_rd;
		if (cmd_in.ese_write)
			s_d.sese = ese_data_in;

		// Arm and error read words
		s_d.arm_rd = cmd_in.arm_read ? s_q.arm_latch : s_q.arm_rd;
		s_d.err_rd = cmd_in.err_read ? err_head : s_q.err_rd;

		// Advisory message: one entry, overwritten by each write
		if (cmd_in.dsp_write)
			s_d.advisory_message_bit = dsp_text_in;
		if (cmd_in.cls)
			s_d.advisory_message_bit = '0;

		// Status byte built from next state so summaries track clears
		s_d.stb = 8'h00;
		s_d.stb[isr_pkg::STB_OP_SUM_BIT]  = |(opc_n & s_d.mask);
		s_d.stb[isr_pkg::STB_EVT_SUM_BIT] = |(evt_n & s_d.sese);
		// Message available follows the output queue, dropped by a clear after a terminator; advisory text
		// has no path into the status byte at all
		s_d.stb[isr_pkg::STB_AVAIL_BIT]   = out_queue_nonempty_in
			& ~(cmd_in.cls & cmd_in.cls_after_term);

		// Output queue flush only when clear directly follows a terminator
		s_d.flush = cmd_in.cls & cmd_in.cls_after_term;

		// Count mirror keeps the count output on a flip-flop
		s_d.err_cnt = err_count;
	end

	// State register, constants only under reset
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_q      <= '0;
			s_q.opc  <= isr_pkg::OPC_RESET;
			s_q.mask <= isr_pkg::MASK_RESET;
			s_q.evt  <= isr_pkg::EVT_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs straight from registers
	assign operation_condition_flags_out = s_q.opc_rd;
	assign arm_latch_out                 = s_q.arm_rd;
	assign err_code_out                  = s_q.err_rd;
	assign standard_event_flags_out      = s_q.evt_rd;
	assign dsp_text_out                  = s_q.advisory_message_bit;
	assign status_byte_out               = s_q.stb;
	assign out_queue_flush_out           = s_q.flush;
	assign err_count_out                 = s_q.err_cnt;

endmodule : isr_status

// ### design/isr_pkg.sv
// Purpose: Shared constants and carriers for the instrument status reporting block
// Assumes: One clock domain, single-cycle command strobes from the command parser
// Notes:   Bit positions and queue sizes are used by the main block and the error queue
package isr_pkg;

	// Operation condition flag positions
	localparam int OPC_RUN_BIT      = 3;
	localparam int OPC_WAIT_BIT     = 5;
	localparam int OPC_OVLD_BIT     = 11;
	localparam int OPC_WIDTH        = 16;

	// Status byte positions
	localparam int STB_AVAIL_BIT    = 4;   // Response bytes waiting
	localparam int STB_EVT_SUM_BIT  = 5;   // Enabled standard events summary
	localparam int STB_OP_SUM_BIT   = 7;   // Enabled operation flags summary

	// Error queue geometry and codes
	localparam int ERRQ_DEPTH       = 30;
	localparam int ERRQ_CODE_W      = 16;
	localparam logic [15:0] ERR_NONE     = 16'h0000;
	localparam logic [15:0] ERR_OVERFLOW = 16'h015E;

	// Reset values
	localparam logic [15:0] OPC_RESET    = 16'h0000;
	localparam logic [15:0] MASK_RESET   = 16'h0000;
	localparam logic [7:0]  EVT_RESET    = 8'h00;
	localparam int MSG_W            = 32;

	// Error push carrier
	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} isr_err_s;

	// Command strobes from the parser
	typedef struct packed {
		logic opc_read;      // Operation register query
		logic mask_write;    // Operation enable command
		logic arm_read;      // Arm latch query
		logic err_read;      // Error query
		logic cls;           // Clear status command
		logic cls_after_term; // Clear status directly after a terminator
		logic dsp_write;     // Advisory line write
		logic esr_read;      // Standard event query
		logic ese_write;     // Standard event enable write
	} isr_cmd_s;

	// Acquisition states seen from the run logic
	typedef enum logic [1:0] {
		ISR_ACQ_STOPPED,
		ISR_ACQ_RUNNING,
		ISR_ACQ_SINGLE
	} isr_acq_e;

endpackage : isr_pkg

// ### design/isr_err_queue.sv
// Purpose: First-in first-out error queue with overflow marker
// Assumes: One push and one pop strobe per cycle at most each
// Notes:   Last slot is reserved for the overflow marker
`timescale 1ns/1ps
module isr_err_queue #(
	parameter int DEPTH = isr_pkg::ERRQ_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// Push side
	input  wire isr_pkg::isr_err_s push_in,
	// Pop and clear
	input  wire logic             pop_in,
	input  wire logic             clear_in,
	// Head and fill
	output logic [15:0]           head_out,
	output logic [5:0]            count_out
);

	// Whole queue state in one packed record
	typedef struct packed {
		logic [DEPTH-1:0][15:0] mem;
		logic [5:0]             cnt;
	} isr_eq_s;

	isr_eq_s q_q;   // Registered state
	isr_eq_s q_d;   // Next state

	localparam logic [5:0] FULL_CNT = 6'(DEPTH);
	localparam logic [5:0] DATA_CNT = 6'(DEPTH - 1);

	// Shift-out on pop keeps the head always at slot 0
	always_comb
	begin
		logic [5:0] c;
		c = q_q.cnt;
		q_d = q_q;
		if (pop_in && c != 6'h00)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
				q_d.mem[i] = q_q.mem[i + 1];
			q_d.mem[DEPTH-1] = 16'h0000;
			c = c - 6'h01;
		end
		if (push_in.valid)
		begin
			if (c < DATA_CNT)
			begin
				q_d.mem[c] = push_in.code;
				c = c + 6'h01;
			end
			else if (c == DATA_CNT)
			begin
				// Newest error dropped, marker takes the reserved slot
				q_d.mem[c] = isr_pkg::ERR_OVERFLOW;
				c = FULL_CNT;
			end
		end
		q_d.cnt = c;
		if (clear_in)
			q_d = '0;
	end

	// State register
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			q_q <= '0;
		else
			q_q <= q_d;
	end

	// Empty queue answers with no-error code
	assign head_out  = (q_q.cnt == 6'h00) ? isr_pkg::ERR_NONE : q_q.mem[0];
	assign count_out = q_q.cnt;

endmodule : isr_err_queue

// ### testbench/isr_status_properties.sv
// Purpose: Port-level checks of the status block
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every instance of the status block
`timescale 1ns/1ps
module isr_status_properties #(
	parameter int MSG_WIDTH = 32
) (
	// Clock and reset
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	// Watched inputs
	input  wire isr_pkg::isr_cmd_s    cmd_in,
	input  wire logic [MSG_WIDTH-1:0] dsp_text_in,
	input  wire logic                 out_queue_nonempty_in,
	// Watched outputs
	input  wire logic [MSG_WIDTH-1:0] dsp_text_out,
	input  wire logic [7:0]           status_byte_out,
	input  wire logic                 out_queue_flush_out,
	input  wire logic [5:0]           err_count_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Clear that also flushes pending responses
	sequence s_term_clear;
		cmd_in.cls && cmd_in.cls_after_term;
	endsequence
	a_avail_follow: assert property (!(cmd_in.cls && cmd_in.cls_after_term) |=>
		status_byte_out[4] == $past(out_queue_nonempty_in))
		else $error("Message-available bit lags its input");
	a_flush_pulse: assert property (s_term_clear |=> out_queue_flush_out)
		else $error("No flush after clear");
	a_flush_cause: assert property (out_queue_flush_out |->
		$past(cmd_in.cls && cmd_in.cls_after_term)) else $error("Stray flush");
	a_stb_unused: assert property (status_byte_out[6] == 1'b0 &&
		status_byte_out[3:0] == 4'h0) else $error("Unused status bit set");
	a_count_max: assert property (err_count_out <= 6'h1E)
		else $error("Error count above depth");
	a_count_step: assert property (!$stable(err_count_out) |->
		err_count_out == $past(err_count_out) + 6'h01 || err_count_out == 6'h00 ||
		err_count_out == $past(err_count_out) - 6'h01) else $error("Count jumped");
	a_cls_queue: assert property (cmd_in.cls |-> ##2 err_count_out == 6'h00)
		else $error("Queue not emptied by clear");
	a_dsp_hold: assert property (cmd_in.dsp_write && !cmd_in.cls |=>
		dsp_text_out == $past(dsp_text_in)) else $error("Advisory text not kept");
	a_cls_msg: assert property (cmd_in.cls && !cmd_in.dsp_write |=>
		dsp_text_out == '0) else $error("Advisory text survives clear");
endmodule : isr_status_properties

bind isr_status isr_status_properties #(.MSG_WIDTH(MSG_WIDTH)) u_isr_status_properties (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd_in),
	.dsp_text_in(dsp_text_in), .out_queue_nonempty_in(out_queue_nonempty_in),
	.dsp_text_out(dsp_text_out), .status_byte_out(status_byte_out),
	.out_queue_flush_out(out_queue_flush_out), .err_count_out(err_count_out));

// ### testbench/isr_ctrl_model.sv
// Purpose: Controller issuing commands and queries
// Assumes: Strobes last one cycle, launched at falling edges
// Notes:   Released data shows the inverse, never a stale value
`timescale 1ns/1ps
module isr_ctrl_model (
	// Clock
	input  wire logic         clk_sys_in,
	// Toward the block
	output isr_pkg::isr_cmd_s cmd_out,
	output logic [31:0]       data_out
);
	// Idle at time zero
	initial
	begin
		cmd_out  = '0;
		data_out = 32'h0000_0000;
	end
	// One strobe with its data, then release
	task automatic issue(input logic [8:0] c, input logic [31:0] d);
		@(negedge clk_sys_in);
		cmd_out  = isr_pkg::isr_cmd_s'(c);
		data_out = d;
		@(negedge clk_sys_in);
		cmd_out  = '0;
		data_out = ~d;
	endtask : issue
endmodule : isr_ctrl_model

// ### testbench/testbench.sv
// Purpose: Self-checking bench of the status block
// Assumes: Inputs change at falling edges
// Notes:   Rows cover mask and condition mixes; queue and clears by hand
`timescale 1ns/1ps
module testbench;
	// Strobe codes in struct order
	localparam logic [8:0] C_OPC = 9'h100, C_MASK = 9'h080, C_ARM = 9'h040, C_ERR = 9'h020;
	localparam logic [8:0] C_CLS = 9'h010, C_TERM = 9'h008, C_DSP = 9'h004, C_ESR = 9'h002;
	localparam logic [8:0] C_ESE = 9'h001;
	// Row: mask, run, overload, expected word, expected summary
	typedef struct packed {logic [15:0] m; logic run; logic ovl; logic [15:0] w; logic s;} isr_row_s;
	isr_row_s rows [5] = '{'{16'hFFFF, 1'b1, 1'b0, 16'h0008, 1'b1},
		'{16'h0000, 1'b1, 1'b1, 16'h0808, 1'b0}, '{16'h0008, 1'b0, 1'b1, 16'h0800, 1'b0},
		'{16'h0800, 1'b0, 1'b1, 16'h0800, 1'b1}, '{16'hFFFF, 1'b0, 1'b0, 16'h0000, 1'b0}};
	logic clk_sys_in = 1'b0, rst_in = 1'b1, acq_running_in = 1'b0, armed_in = 1'b0;
	logic input_overload_in = 1'b0, out_queue_nonempty_in = 1'b0;
	logic [7:0] std_event_in = 8'h00;
	isr_pkg::isr_err_s err_push_in = '0;
	isr_pkg::isr_cmd_s cmd;
	logic [31:0] data, dsp_text_out;
	logic [15:0] opc_out, err_code_out;
	logic [7:0] std_flags_out, status_byte_out;
	logic arm_latch_out, out_queue_flush_out;
	logic [5:0] err_count_out;
	int mismatches = 0, n_compared = 0;
	// 250 MHz
	always #2 clk_sys_in = ~clk_sys_in;
	isr_ctrl_model u_isr_ctrl_model (.clk_sys_in(clk_sys_in), .cmd_out(cmd), .data_out(data));
	isr_status #(.MSG_WIDTH(32)) u_isr_status (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_in(cmd), .mask_data_in(data[15:0]), .ese_data_in(data[7:0]), .dsp_text_in(data),
		.acq_running_in(acq_running_in), .armed_in(armed_in), .input_overload_in(input_overload_in),
		.std_event_in(std_event_in), .err_push_in(err_push_in),
		.out_queue_nonempty_in(out_queue_nonempty_in), .operation_condition_flags_out(opc_out),
		.arm_latch_out(arm_latch_out), .err_code_out(err_code_out),
		.standard_event_flags_out(std_flags_out), .dsp_text_out(dsp_text_out),
		.status_byte_out(status_byte_out), .out_queue_flush_out(out_queue_flush_out),
		.err_count_out(err_count_out));
	// Word compare, four-state exact
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_w
	// Single-bit compare
	task automatic chk_b(input logic got, input logic exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask : chk_b
	// Wait whole cycles
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : cyc
	// Single-cycle synchronous pulses
	task automatic ev(input logic [7:0] e);
		@(negedge clk_sys_in);
		std_event_in = e;
		@(negedge clk_sys_in);
		std_event_in = 8'h00;
	endtask : ev
	// Verdict
	task automatic conclude;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// Hang guard, well beyond the few hundred cycles used
	initial
	begin
		repeat (3000) @(posedge clk_sys_in);
		mismatches++;
		$display("MISMATCH %0t watchdog expired", $time);
		conclude();
	end
	initial
	begin
		cyc(2);
		rst_in = 1'b0;
		chk_w(status_byte_out, 0);
		chk_w(err_count_out, 0);
		foreach (rows[i])
		begin
			acq_running_in = rows[i].run;
			input_overload_in = rows[i].ovl;
			u_isr_ctrl_model.issue(C_MASK, {16'h0000, rows[i].m});
			cyc(4);
			// First read drops stale flags; live ones come back
			u_isr_ctrl_model.issue(C_OPC, 32'h0);
			cyc(4);
			chk_b(status_byte_out[7], rows[i].s);
			u_isr_ctrl_model.issue(C_OPC, 32'h0);
			chk_w(opc_out, rows[i].w);
		end
		u_isr_ctrl_model.issue(C_MASK, 32'h0000_0020);
		armed_in = 1'b1;
		cyc(5);
		chk_b(status_byte_out[7], 1'b1);
		u_isr_ctrl_model.issue(C_OPC, 32'h0);
		chk_w(opc_out, 32'h0000_0020);
		u_isr_ctrl_model.issue(C_ARM, 32'h0);
		chk_b(arm_latch_out, 1'b1);
		u_isr_ctrl_model.issue(C_ARM, 32'h0);
		chk_b(arm_latch_out, 1'b0);
		// Overfill: 29 codes, marker, two dropped
		for (int i = 1; i <= 31; i++)
		begin
			@(negedge clk_sys_in);
			err_push_in = '{1'b1, 16'(i)};
		end
		@(negedge clk_sys_in);
		err_push_in = '0;
		cyc(2);
		chk_w(err_count_out, 30);
		for (int i = 1; i <= 31; i++)
		begin
			u_isr_ctrl_model.issue(C_ERR, 32'h0);
			chk_w(err_code_out, i < 30 ? i : (i == 30 ? 32'h0000_015E : 0));
		end
		cyc(2);
		chk_w(err_count_out, 0);
		u_isr_ctrl_model.issue(C_ESE, 32'h0000_0004);
		ev(8'h02);
		cyc(2);
		chk_b(status_byte_out[5], 1'b0);
		u_isr_ctrl_model.issue(C_ESR, 32'h0);
		chk_w(std_flags_out, 32'h0000_0002);
		ev(8'h04);
		out_queue_nonempty_in = 1'b1;
		u_isr_ctrl_model.issue(C_DSP, 32'hA5C3_0F96);
		chk_w(dsp_text_out, 32'hA5C3_0F96);
		chk_w(status_byte_out, 32'h0000_00B0);
		// Fresh arming so the clear below has a set latch to drop
		armed_in = 1'b0;
		cyc(4);
		armed_in = 1'b1;
		cyc(4);
		@(negedge clk_sys_in);
		err_push_in = '{1'b1, 16'h0007};
		@(negedge clk_sys_in);
		err_push_in = '0;
		u_isr_ctrl_model.issue(C_CLS, 32'h0);
		cyc(2);
		chk_w(err_count_out, 0);
		chk_w(dsp_text_out, 0);
		chk_w(status_byte_out, 32'h0000_0010);
		u_isr_ctrl_model.issue(C_ARM, 32'h0);
		chk_b(arm_latch_out, 1'b0);
		u_isr_ctrl_model.issue(C_ESR, 32'h0);
		chk_w(std_flags_out, 0);
		u_isr_ctrl_model.issue(C_OPC, 32'h0);
		chk_w(opc_out, 0);
		u_isr_ctrl_model.issue(C_CLS | C_TERM, 32'h0);
		chk_b(out_queue_flush_out, 1'b1);
		chk_b(status_byte_out[4], 1'b0);
		conclude();
	end
endmodule : testbench
